// File: odc_pkg.sv
// shared constants and types for the output divider channel
package odc_pkg;

	// apb register byte offsets
	localparam logic [7:0] ODC_OFF_CTRL   = 8'h00;
	localparam logic [7:0] ODC_OFF_DIVLO  = 8'h04;
	localparam logic [7:0] ODC_OFF_DIVHI  = 8'h08;
	localparam logic [7:0] ODC_OFF_DELAY  = 8'h0C;
	localparam logic [7:0] ODC_OFF_SLIP   = 8'h10;
	localparam logic [7:0] ODC_OFF_STATUS = 8'h14;

	// control word and delay fine field positions
	localparam int ODC_CTRL_EN_POS    = 0;
	localparam int ODC_CTRL_HP_POS    = 1;
	localparam int ODC_CTRL_SLIPEN_POS = 2;
	localparam int ODC_CTRL_SYNCEN_POS = 3;
	localparam int ODC_CTRL_MSLIP_POS = 4;
	localparam int ODC_CTRL_MUX_POS   = 5;
	localparam int ODC_CTRL_START_POS = 7;
	localparam int ODC_DLY_FINE_POS   = 8;

	// widths
	localparam int ODC_DIV_W   = 12;
	localparam int ODC_DIVLO_W = 8;
	localparam int ODC_DIVHI_W = 4;
	localparam int ODC_DLY_W   = 5;
	localparam int ODC_PAIR_W  = 7;

	// reset values
	localparam logic [31:0] ODC_CTRL_RST  = 32'h0000_0000;
	localparam logic [11:0] ODC_DIV_RST   = 12'h001;
	localparam logic [11:0] ODC_SLIP_RST  = 12'h001;

	// output source codes
	localparam logic [1:0] ODC_SRC_DIV   = 2'h0;
	localparam logic [1:0] ODC_SRC_ADLY  = 2'h1;
	localparam logic [1:0] ODC_SRC_PAIR  = 2'h2;
	localparam logic [1:0] ODC_SRC_VCO   = 2'h3;

	// launch behaviour codes
	localparam logic [1:0] ODC_START_ASYNC = 2'h0;
	localparam logic [1:0] ODC_START_PULSE = 2'h3;

	// channel state machine
	typedef enum logic [4:0]
	{
		ODC_ST_OFF  = 5'b00001,
		ODC_ST_RUN  = 5'b00010,
		ODC_ST_SLIP = 5'b00100,
		ODC_ST_SYNC = 5'b01000,
		ODC_ST_IDLE = 5'b10000
	} odc_state_type;

endpackage : odc_pkg

// File: odc_div_if.sv
// carrier between the channel controller and its divider core
`timescale 1ns/1ps
interface odc_div_if;
	import odc_pkg::*;
	logic [ODC_DIV_W-1:0] ratio;
	logic [ODC_DLY_W-1:0] coarse;
	logic                 run;
	logic                 gate;
	logic                 rephase;
	logic                 slip;
	logic                 div_out;
	logic                 busy;

	modport ctrl (output ratio, coarse, run, gate, rephase, slip, input div_out, busy);
	modport core (input ratio, coarse, run, gate, rephase, slip, output div_out, busy);
endinterface : odc_div_if

// File: odc_div_core.sv
// divider core: half-cycle phase counter with 50% duty for ratio one and even ratios
`timescale 1ns/1ps
module odc_div_core
	import odc_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// channel side
	odc_div_if.core   dv
);

	typedef struct packed
	{
		logic [ODC_DIV_W:0] half;
		logic               out;
		logic               busy;
	} odc_core_type;

	odc_core_type s_q;
	odc_core_type s_d;
	logic [ODC_DIV_W:0] per;
	logic [ODC_DIV_W:0] hi;

	// counts half vco cycles: period is 2*ratio half cycles, high for ratio
	always_comb
	begin
		per  = {dv.ratio, 1'b0};
		hi   = {1'b0, dv.ratio};
		s_d  = s_q;
		s_d.busy = 1'b0;
		if (!dv.run)
		begin
			s_d.half = '0;
			s_d.out  = 1'b0;
		end
		else if (dv.rephase)
		begin
			s_d.half = {8'h00, dv.coarse};
			s_d.out  = 1'b0;
			s_d.busy = 1'b1;
		end
		else if (dv.gate)
			s_d.busy = 1'b1;
		else
		begin
			if (s_q.half + 13'h002 >= per)
				s_d.half = s_q.half + 13'h002 - per;
			else
				s_d.half = s_q.half + 13'h002;
			s_d.out = (dv.ratio == 12'h001) ? ~s_q.out : (s_d.half < hi);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign dv.div_out = s_q.out;
	assign dv.busy    = s_q.busy;

endmodule : odc_div_core

// File: odc_channel.sv
// one output divider channel: apb registers, event control and output select
`timescale 1ns/1ps
//Contract
// - enable clear keeps channel fully off
// - run gated by launch, pair gate, sleep
// - ratio held in upper and lower words
// - high bias bit raises divider bias
// - coarse field shifts phase up to 15.5
// - fine trim path only on source 01
// - source codes divider, delayed, pair, vco
// - fundamental by ratio one or vco path
// - slip accept bit gates broadcast slips
// - multislip auto-starts after realign or burst when slip accept bit is set
// - realign accept bit rephases the divider
// - toggling realign accept never disturbs divider
// - code 00 free phase, realign if accepted
// - code 11 power around pulse bursts
// - ratios 1 to 4094, half duty; odd ratios above one are not 50% duty
// - coarse step equals half vco cycle
// - multislip repeats by 12-bit count
module odc_channel
	import odc_pkg::*;
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// global controls and broadcast events
	input  wire logic [odc_pkg::ODC_PAIR_W-1:0] pair_gate_i,
	input  wire logic [2:0]  pair_idx_i,
	input  wire logic        sleep_i,
	input  wire logic        slip_req_i,
	input  wire logic        realign_req_i,
	input  wire logic        burst_warn_i,
	input  wire logic        burst_start_i,
	input  wire logic        burst_end_i,
	// clock sources
	input  wire logic        pair_clk_i,
	input  wire logic        vco_clk_i,
	// channel outputs
	output logic             chan_out_o,
	output logic             chan_on_o,
	output logic             high_bias_o,
	output logic [odc_pkg::ODC_DLY_W-1:0] fine_trim_o,
	output logic             trim_path_o,
	output logic             phase_busy_o
);

	////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed
	{
		logic [8:0]           ctrl;
		logic [7:0]           div_lo;
		logic [3:0]           div_hi;
		logic [ODC_DLY_W-1:0] coarse;
		logic [ODC_DLY_W-1:0] fine;
		logic [ODC_DIV_W-1:0] slip_cnt;
		logic [ODC_DIV_W-1:0] slip_left;
		logic                 realign_pend;
		odc_state_type        st;
		logic                 powered;
		logic                 in_burst;
		logic [31:0]          rdata;
		logic                 ready;
		logic                 err;
		logic                 out;
		logic                 on;
	} odc_chan_type;

	odc_chan_type s_q;
	odc_chan_type s_d;
	odc_div_if    dv ();

	logic                 wr_en;
	logic                 rd_en;
	logic                 en;
	logic                 hp;
	logic                 slip_acc;
	logic                 sync_acc;
	logic                 mslip;
	logic [1:0]           src;
	logic [1:0]           start;
	logic                 permit;
	logic                 addr_ok;
	logic                 bias_d;
	logic                 trim_d;
	logic                 busy_d;

	////////////////////////////////////////////////////////////////////////
	// divider core
	odc_div_core u_core
	(
		.clk_i (mclk_i),
		.rst_i (sys_rst_i),
		.dv    (dv)
	);

	////////////////////////////////////////////////////////////////////////
	// decode
	always_comb
	begin
		en       = s_q.ctrl[ODC_CTRL_EN_POS];
		hp       = s_q.ctrl[ODC_CTRL_HP_POS];
		slip_acc = s_q.ctrl[ODC_CTRL_SLIPEN_POS];
		sync_acc = s_q.ctrl[ODC_CTRL_SYNCEN_POS];
		mslip    = s_q.ctrl[ODC_CTRL_MSLIP_POS];
		src      = s_q.ctrl[ODC_CTRL_MUX_POS +: 2];
		start    = s_q.ctrl[ODC_CTRL_START_POS +: 2];
		permit   = en && pair_gate_i[pair_idx_i] && !sleep_i;
		wr_en    = psel_i && penable_i && pwrite_i && s_q.ready;
		rd_en    = psel_i && !penable_i && !pwrite_i;
	end

	////////////////////////////////////////////////////////////////////////
	// address map
	always_comb
	begin
		case (paddr_i)
			ODC_OFF_CTRL,
			ODC_OFF_DIVLO,
			ODC_OFF_DIVHI,
			ODC_OFF_DELAY,
			ODC_OFF_SLIP,
			ODC_OFF_STATUS: addr_ok = 1'b1;
			default:        addr_ok = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		s_d = s_q;

		// apb: setup cycle prepares the answer, access cycle completes
		s_d.ready = psel_i && penable_i && !s_q.ready;
		s_d.err   = psel_i && penable_i && !s_q.ready && !addr_ok;
		if (rd_en)
		begin
			case (paddr_i)
				ODC_OFF_CTRL:   s_d.rdata = {23'h000000, s_q.ctrl};
				ODC_OFF_DIVLO:  s_d.rdata = {24'h000000, s_q.div_lo};
				ODC_OFF_DIVHI:  s_d.rdata = {28'h0000000, s_q.div_hi};
				ODC_OFF_DELAY:  s_d.rdata = {19'h00000, s_q.fine, 3'h0, s_q.coarse};
				ODC_OFF_SLIP:   s_d.rdata = {20'h00000, s_q.slip_cnt};
				ODC_OFF_STATUS: s_d.rdata = {12'h000, s_q.slip_left, s_q.st, 2'h0,
				                             s_q.powered};
				default:        s_d.rdata = 32'h0000_0000;
			endcase
		end
		if (wr_en)
		begin
			case (paddr_i)
				ODC_OFF_CTRL:  s_d.ctrl   = pwdata_i[8:0];
				ODC_OFF_DIVLO: s_d.div_lo = pwdata_i[ODC_DIVLO_W-1:0];
				ODC_OFF_DIVHI: s_d.div_hi = pwdata_i[ODC_DIVHI_W-1:0];
				ODC_OFF_DELAY:
				begin
					s_d.coarse = pwdata_i[ODC_DLY_W-1:0];
					s_d.fine   = pwdata_i[ODC_DLY_FINE_POS +: ODC_DLY_W];
				end
				ODC_OFF_SLIP:  s_d.slip_cnt = pwdata_i[ODC_DIV_W-1:0];
				default:       s_d.slip_cnt = s_q.slip_cnt;
			endcase
		end

		// burst window: opened by warning, closed by burst end
		if (!permit)
			s_d.in_burst = 1'b0;
		else if (burst_warn_i)
			s_d.in_burst = 1'b1;
		else if (burst_end_i)
			s_d.in_burst = 1'b0;

		// launch behaviour: free running or powered around bursts
		if (!permit)
			s_d.powered = 1'b0;
		else if (start == ODC_START_PULSE)
			s_d.powered = s_d.in_burst;
		else
			s_d.powered = 1'b1;

		// channel sequencer
		case (s_q.st)
			ODC_ST_OFF:
			begin
				s_d.slip_left    = '0;
				s_d.realign_pend = 1'b0;
				if (s_d.powered)
					s_d.st = (start == ODC_START_PULSE) ? ODC_ST_IDLE : ODC_ST_RUN;
			end
			ODC_ST_IDLE, ODC_ST_RUN:
			begin
				if (!s_d.powered)
					s_d.st = ODC_ST_OFF;
				else if ((realign_req_i && sync_acc) ||
				         (burst_start_i && start == ODC_START_PULSE))
				begin
					s_d.st = ODC_ST_SYNC;
					s_d.realign_pend = 1'b1;
				end
				else if (slip_req_i && slip_acc)
				begin
					s_d.st = ODC_ST_SLIP;
					s_d.slip_left = mslip ? s_q.slip_cnt : 12'h001;
				end
			end
			ODC_ST_SYNC:
			begin
				s_d.realign_pend = 1'b0;
				if (mslip && slip_acc)
				begin
					s_d.st = ODC_ST_SLIP;
					s_d.slip_left = s_q.slip_cnt;
				end
				else
					s_d.st = ODC_ST_RUN;
			end
			ODC_ST_SLIP:
			begin
				if (!s_d.powered)
					s_d.st = ODC_ST_OFF;
				else if (s_q.slip_left <= 12'h001)
				begin
					s_d.slip_left = '0;
					s_d.st = ODC_ST_RUN;
				end
				else
					s_d.slip_left = s_q.slip_left - 12'h001;
			end
			default: s_d.st = ODC_ST_OFF;
		endcase

		// output source select
		case (src)
			ODC_SRC_DIV:  s_d.out = dv.div_out;
			ODC_SRC_ADLY: s_d.out = dv.div_out;
			ODC_SRC_PAIR: s_d.out = pair_clk_i;
			ODC_SRC_VCO:  s_d.out = vco_clk_i;
			default:      s_d.out = 1'b0;
		endcase
		if (!s_d.powered)
			s_d.out = 1'b0;
		s_d.on = s_d.powered;
	end

	////////////////////////////////////////////////////////////////////////
	// divider controls
	always_comb
	begin
		dv.ratio   = {s_q.div_hi, s_q.div_lo};
		dv.coarse  = s_q.coarse;
		dv.run     = s_q.powered && (src == ODC_SRC_DIV || src == ODC_SRC_ADLY);
		dv.rephase = s_q.realign_pend;
		dv.slip    = (s_q.st == ODC_ST_SLIP);
		dv.gate    = (s_q.st == ODC_ST_SLIP) || (s_q.st == ODC_ST_SYNC);
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			s_q          <= '0;
			s_q.ctrl     <= ODC_CTRL_RST[8:0];
			s_q.div_lo   <= ODC_DIV_RST[7:0];
			s_q.div_hi   <= ODC_DIV_RST[11:8];
			s_q.slip_cnt <= ODC_SLIP_RST;
			s_q.st       <= ODC_ST_OFF;
		end
		else
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////
	// output inputs: follow next power state so bias and trim never outlast it
	always_comb
	begin
		bias_d = s_d.ctrl[ODC_CTRL_HP_POS] && s_d.powered;
		trim_d = s_d.powered && (s_d.ctrl[ODC_CTRL_MUX_POS +: 2] == ODC_SRC_ADLY);
		busy_d = (s_q.st == ODC_ST_SLIP) || (s_q.st == ODC_ST_SYNC) || dv.busy;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			high_bias_o  <= 1'b0;
			fine_trim_o  <= '0;
			trim_path_o  <= 1'b0;
			phase_busy_o <= 1'b0;
		end
		else
		begin
			high_bias_o  <= bias_d;
			fine_trim_o  <= s_q.fine;
			trim_path_o  <= trim_d;
			phase_busy_o <= busy_d;
		end
	end

	assign prdata_o   = s_q.rdata;
	assign pready_o   = s_q.ready;
	assign pslverr_o  = s_q.err;
	assign chan_out_o = s_q.out;
	assign chan_on_o  = s_q.on;

endmodule : odc_channel

// File: odc_timer_model.sv
// behavioural model of the central timer that broadcasts channel events
`timescale 1ns/1ps
module odc_timer_model
#(
	parameter int WARN_GAP = 4,
	parameter int BURST_LEN = 8
)
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// bench request
	input wire logic go_i,
	input wire logic [1:0] cmd_i,
	// broadcast events
	output logic slip_o,
	output logic realign_o,
	output logic warn_o,
	output logic start_o,
	output logic end_o
);
	logic [7:0] cnt_q;
	always_ff @(posedge mclk_i or posedge sys_rst_i)
		if (sys_rst_i)
		begin
			{slip_o, realign_o, warn_o, start_o, end_o} <= 5'h00;
			cnt_q <= 8'h00;
		end
		else
		begin
			slip_o <= go_i && cmd_i == 2'h0;
			realign_o <= go_i && cmd_i == 2'h1;
			warn_o <= go_i && cmd_i == 2'h2;
			cnt_q <= (go_i && cmd_i == 2'h2) ? 8'h01 : ((cnt_q != 8'h00) ? cnt_q + 8'h01 : 8'h00);
			start_o <= cnt_q == 8'(WARN_GAP);
			end_o <= cnt_q == 8'(WARN_GAP + BURST_LEN);
		end
endmodule : odc_timer_model

// File: odc_channel_properties.sv
// port checker for the output divider channel
`timescale 1ns/1ps
module odc_channel_chk
(
	// clock, reset, apb
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// events and outputs
	input wire logic sleep_i,
	input wire logic slip_req_i,
	input wire logic realign_req_i,
	input wire logic burst_start_i,
	input wire logic chan_out_o,
	input wire logic chan_on_o,
	input wire logic high_bias_o,
	input wire logic trim_path_o,
	input wire logic phase_busy_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	AST_READY_ONE: assert property (pready_o |=> !pready_o)
		else $error("ready too long");
	AST_READY_LAT: assert property (psel_i && penable_i && $past(psel_i && !penable_i) |=> pready_o)
		else $error("ready late");
	AST_ERR_MAP: assert property (pready_o |-> pslverr_o == (paddr_i > 8'h14 || paddr_i[1:0] != 2'h0))
		else $error("bad error flag");
	AST_RDATA_HOLD: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
		else $error("read data moved");
	AST_BIAS_ON: assert property (high_bias_o |-> chan_on_o)
		else $error("bias while off");
	AST_TRIM_ON: assert property (trim_path_o |-> chan_on_o)
		else $error("trim while off");
	AST_OFF_QUIET: assert property (!chan_on_o && $past(!chan_on_o) |-> !chan_out_o)
		else $error("output while off");
	AST_SLEEP_OFF: assert property ($rose(chan_on_o) |-> !$past(sleep_i))
		else $error("woke in sleep");
	AST_BUSY_CAUSE: assert property ($rose(phase_busy_o) |-> $past(realign_req_i, 2) || $past(slip_req_i, 2) || $past(burst_start_i, 2))
		else $error("busy without event");
endmodule : odc_channel_chk
bind odc_channel odc_channel_chk odc_channel_chk_i (.mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.prdata_o, .pready_o, .pslverr_o, .sleep_i, .slip_req_i, .realign_req_i, .burst_start_i, .chan_out_o,
	.chan_on_o, .high_bias_o, .trim_path_o, .phase_busy_o);

// File: output_divider_channel_control_tb.sv
// self-checking bench for one output divider channel
`timescale 1ns/1ps
module output_divider_channel_control_tb;
	import odc_pkg::*;
	logic mclk_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o;
	logic [6:0] pair_gate_i = 7'h7F;
	logic [2:0] pair_idx_i = 3'h0;
	logic sleep_i = 1'b0, pair_clk_i = 1'b0, vco_clk_i = 1'b0, go = 1'b0;
	logic [1:0] cmd = 2'h0;
	logic pready_o, pslverr_o, slip_req_i, realign_req_i, burst_warn_i, burst_start_i, burst_end_i;
	logic chan_out_o, chan_on_o, high_bias_o, trim_path_o, phase_busy_o;
	logic [4:0] fine_trim_o;
	logic [32:0] q[$];
	int error_cnt = 0, n_checks = 0;
	always #12.5 mclk_i = ~mclk_i;
	odc_channel odc_channel_i (.mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .pair_gate_i, .pair_idx_i, .sleep_i, .slip_req_i, .realign_req_i,
		.burst_warn_i, .burst_start_i, .burst_end_i, .pair_clk_i, .vco_clk_i, .chan_out_o, .chan_on_o,
		.high_bias_o, .fine_trim_o, .trim_path_o, .phase_busy_o);
	odc_timer_model odc_timer_model_i (.mclk_i, .sys_rst_i, .go_i(go), .cmd_i(cmd), .slip_o(slip_req_i),
		.realign_o(realign_req_i), .warn_o(burst_warn_i), .start_o(burst_start_i), .end_o(burst_end_i));
	////////////////////////////////////////////////////////////////
	task check(input logic [32:0] got, input logic [32:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task stop_test;
		$display("checks=%0d mismatches=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 20);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		check(33'(n < 20), 33'h1);
		if (n >= 20)
			stop_test();
	endtask : apb
	task rd(input logic [7:0] a, input logic [32:0] e);
		q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task wt(input logic [1:0] m, input logic [1:0] v);
		int n;
		n = 0;
		while (({chan_on_o, phase_busy_o} & m) !== v && n < 40)
		begin
			@(posedge mclk_i);
			n++;
		end
		check(33'({chan_on_o, phase_busy_o} & m), 33'(v));
		if (n >= 40)
			stop_test();
	endtask : wt
	task ev(input logic [1:0] c);
		@(posedge mclk_i);
		go <= 1'b1;
		cmd <= c;
		@(posedge mclk_i);
		go <= 1'b0;
	endtask : ev
	task blen(output int l);
		l = 0;
		wt(2'b01, 2'b01);
		while (phase_busy_o === 1'b1 && l < 200)
		begin
			@(posedge mclk_i);
			l++;
		end
		check(33'(l < 200), 33'h1);
		if (l >= 200)
			stop_test();
	endtask : blen
	////////////////////////////////////////////////////////////////
	always @(posedge mclk_i)
		if (pready_o === 1'b1 && pwrite_i === 1'b0 && q.size() > 0)
			check({pslverr_o, prdata_o}, q.pop_front());
	initial
	begin
		int r, k, i, l1, l5, lr;
		logic [11:0] dv;
		logic h0, h1, v, b;
		logic [7:0] ra[6];
		logic [32:0] rv[6];
		ra = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
		rv = '{33'h0, 33'h1, 33'h0, 33'h0, 33'h1, 33'h1_0000_0000};
		h0 = 1'b0;
		h1 = 1'b0;
		void'($urandom(32'hDE5EC3CE));
		repeat (4) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		for (k = 0; k < 6; k++)
			rd(ra[k], rv[k]);
		rd(ODC_OFF_STATUS, 33'h8);
		dv = 12'(($urandom % 4094) + 1);
		apb(1'b1, ODC_OFF_DIVLO, {24'h0, dv[7:0]});
		apb(1'b1, ODC_OFF_DIVHI, {28'h0, dv[11:8]});
		rd(ODC_OFF_DIVLO, {25'h0, dv[7:0]});
		rd(ODC_OFF_DIVHI, {29'h0, dv[11:8]});
		$display("register test done");
		pair_idx_i <= 3'($urandom % 7);
		r = $urandom;
		apb(1'b1, ODC_OFF_DELAY, {19'h0, r[12:8], 3'h0, r[4:0]});
		apb(1'b1, ODC_OFF_CTRL, 32'h23);
		wt(2'b10, 2'b10);
		@(posedge mclk_i);
		check({high_bias_o, trim_path_o, fine_trim_o}, {2'b11, r[12:8]});
		sleep_i <= 1'b1;
		wt(2'b10, 2'b00);
		sleep_i <= 1'b0;
		wt(2'b10, 2'b10);
		pair_gate_i[pair_idx_i] <= 1'b0;
		wt(2'b10, 2'b00);
		pair_gate_i <= 7'h7F;
		apb(1'b1, ODC_OFF_CTRL, 32'h0);
		wt(2'b10, 2'b00);
		check({high_bias_o, trim_path_o}, 2'b00);
		$display("power test done");
		apb(1'b1, ODC_OFF_DIVLO, 32'h0);
		apb(1'b1, ODC_OFF_DIVHI, 32'h0);
		for (k = 2; k < 4; k++)
		begin
			apb(1'b1, ODC_OFF_CTRL, 32'h1 | (k << 5));
			wt(2'b10, 2'b10);
			for (i = 0; i < 20; i++)
			begin
				@(posedge mclk_i);
				if (i > 3)
					check(chan_out_o, h1 ^ (k == 3));
				h1 = h0;
				v = 1'($urandom);
				h0 = v;
				pair_clk_i <= v;
				vco_clk_i <= ~v;
			end
		end
		$display("mux test done");
		for (k = 0; k < 4; k++)
		begin
			apb(1'b1, ODC_OFF_CTRL, (k[0] ^ k[1]) ? 32'h9 : 32'h5);
			wt(2'b10, 2'b10);
			ev(2'(k >> 1));
			b = 1'b0;
			repeat (10)
			begin
				@(posedge mclk_i);
				b = b | phase_busy_o;
			end
			check(b, !k[0]);
		end
		apb(1'b1, ODC_OFF_SLIP, 32'h1);
		apb(1'b1, ODC_OFF_CTRL, 32'h1D);
		ev(2'h0);
		blen(l1);
		apb(1'b1, ODC_OFF_SLIP, 32'h5);
		ev(2'h0);
		blen(l5);
		check(33'(l5 - l1), 33'h4);
		ev(2'h1);
		blen(lr);
		check(33'(lr > l5), 33'h1);
		$display("event test done");
		apb(1'b1, ODC_OFF_DIVLO, 32'h40);
		apb(1'b1, ODC_OFF_CTRL, 32'h189);
		repeat (4) @(posedge mclk_i);
		check(chan_on_o, 1'b0);
		ev(2'h2);
		wt(2'b10, 2'b10);
		wt(2'b01, 2'b01);
		wt(2'b10, 2'b00);
		$display("burst test done");
		stop_test();
	end
endmodule : output_divider_channel_control_tb
